/* core/adc_seq_pkg.sv */
// Package with register map, field positions and timing constants of the sequencer.
package adc_seq_pkg;
    localparam int ADDR_W = 6;
    localparam logic [5:0] OFF_CTRL1 = 6'h00;
    localparam logic [5:0] OFF_CTRL3 = 6'h04;
    localparam logic [5:0] OFF_STATUS = 6'h08;
    localparam logic [5:0] OFF_MASK = 6'h0C;
    localparam logic [5:0] OFF_MODE = 6'h10;
    localparam int BIT_ENABLE = 15;
    localparam int BIT_DONE = 0;
    localparam int BIT_SAMPLE = 1;
    localparam int BIT_AUTO_SAMPLE = 2;
    localparam int TRIG_LSB = 5;
    localparam int TRIG_MSB = 7;
    localparam int SAMC_LSB = 8;
    localparam int SAMC_MSB = 12;
    localparam int DIV_LSB = 0;
    localparam int DIV_MSB = 7;
    localparam int BIT_RES12 = 0;
    localparam int ST_CONV_DONE = 0;
    localparam int ST_SAMPLE_START = 1;
    localparam logic [2:0] TRIG_MANUAL = 3'h0;
    localparam logic [2:0] TRIG_EXT_EXTERNAL_INTERRUPT_ZERO = 3'h1;
    localparam logic [2:0] TRIG_TIMER_A = 3'h2;
    localparam logic [2:0] TRIG_PWM_EVENT = 3'h3;
    localparam logic [2:0] TRIG_TIMER_B = 3'h4;
    localparam logic [2:0] TRIG_AUTO = 3'h7;
    localparam logic [4:0] CONV_CYC_10BIT = 5'hC;
    localparam logic [4:0] CONV_CYC_12BIT = 5'hE;
    localparam logic [1:0] START_LATENCY = 2'h2;
    localparam logic [7:0] DIV_RESET = 8'h03;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_LATENCY, ST_CONVERT} seq_state_t;
endpackage

/* core/adc_tad_gen.sv */
// Converter clock period tick generator derived from the system clock.
`timescale 1ns/1ps
module adc_tad_gen #(
    parameter int DIV_W = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic run,
    input wire logic [DIV_W-1:0] div,
    output logic tick
);
    logic [DIV_W-1:0] cnt_r;

    // The count restarts while run is low so the first period after run rises is whole.
    always_ff @(posedge clk)
    begin
        if (!rstn || !run || cnt_r >= div)
        begin
            cnt_r <= '0;
        end
        else
        begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign tick = run && (cnt_r >= div);
endmodule

/* core/adc_trig_sync.sv */
// Two-stage synchroniser with rising edge detection for one trigger input.
`timescale 1ns/1ps
module adc_trig_sync (
    input wire logic clk,
    input wire logic rstn,
    input wire logic async_in,
    output logic pulse
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end
        else
        begin
            meta_r <= async_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign pulse = sync_r && !prev_r;
endmodule

/* core/adc_sample_convert_sequencer.sv */
// Sample and conversion sequencer for a successive approximation converter.
//
// Contract
// - Sample, hold, then convert; phases separately controlled.
// - Sampling starts after conversion or by sample bit.
// - Auto-sample bit chooses manual or automatic sampling.
// - Auto sampling lasts auto-sample-time converter periods.
// - Sample time field covers zero to 31 periods.
// - Conversion trigger ends sampling and starts converting.
// - Conversion takes 12 or 14 converter periods.
// - Trigger select field picks the conversion source.
// - Trigger codes: manual, external_interrupt_zero, timer, pwm, timer, auto.
// - All six sample and conversion combinations supported.
// - Manual mode: set samples, clear converts.
// - Auto sample restarts; clearing sample bit converts.
// - Code 111 ends sampling on internal counter.
// - Fixed latency precedes each conversion start.
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module adc_sample_convert_sequencer #(
    parameter int DIV_W = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_external_interrupt_zero_trig,
    input wire logic timer_a_trig,
    input wire logic pwm_event_trig,
    input wire logic timer_b_trig,
    output logic sample_connect,
    output logic convert_active,
    output logic conv_done_pulse,
    output logic irq
);
    logic enable_r;
    logic sample_control_bit_r;
    logic auto_sample_enable_r;
    logic done_r;
    logic [2:0] trig_sel_r;
    logic [4:0] samc_r;
    logic [DIV_W-1:0] div_r;
    logic res12_r;
    logic [1:0] status_r;
    logic [1:0] mask_r;
    logic [4:0] cnt_r;
    logic [1:0] lat_r;
    adc_seq_pkg::seq_state_t state_r;

    logic aw_hold_r;
    logic w_hold_r;
    logic [5:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic wr_fire;
    logic rd_fire;
    logic wr_ctrl1;
    logic sample_control_bit_clear_wr;
    logic sample_control_bit_set_wr;
    logic tad_tick;
    logic hw_trig;
    logic soc;
    logic conv_end;
    logic sample_control_bit_start;
    logic ext_p;
    logic tma_p;
    logic pwm_p;
    logic tmb_p;
    logic [31:0] rdata_nxt;

    // Write channel: address and data are taken in either order.
    assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
    assign wr_fire = aw_hold_r && w_hold_r && !s_axi_bvalid;

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= 6'h00;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= adc_seq_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_r[5:2] <= 4'h4 && awaddr_r[1:0] == 2'h0)
                    ? adc_seq_pkg::RESP_OKAY : adc_seq_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign wr_ctrl1 = wr_fire && awaddr_r == adc_seq_pkg::OFF_CTRL1 && wstrb_r[0];
    assign sample_control_bit_set_wr = wr_ctrl1 && wdata_r[adc_seq_pkg::BIT_SAMPLE];
    assign sample_control_bit_clear_wr = wr_ctrl1 && !wdata_r[adc_seq_pkg::BIT_SAMPLE] && sample_control_bit_r;

    // Configuration fields. Trigger select and auto-sample changes while enabled are
    // accepted and act at once; the sequence in flight finishes in the new mode.
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            enable_r <= 1'b0;
            auto_sample_enable_r <= 1'b0;
            trig_sel_r <= adc_seq_pkg::TRIG_MANUAL;
            samc_r <= 5'h00;
            div_r <= DIV_W'(adc_seq_pkg::DIV_RESET);
            res12_r <= 1'b0;
            mask_r <= 2'h0;
        end
        else if (wr_fire)
        begin
            if (awaddr_r == adc_seq_pkg::OFF_CTRL1 && wstrb_r[0])
            begin
                auto_sample_enable_r <= wdata_r[adc_seq_pkg::BIT_AUTO_SAMPLE];
                trig_sel_r <= wdata_r[adc_seq_pkg::TRIG_MSB:adc_seq_pkg::TRIG_LSB];
            end
            if (awaddr_r == adc_seq_pkg::OFF_CTRL1 && wstrb_r[1])
            begin
                enable_r <= wdata_r[adc_seq_pkg::BIT_ENABLE];
            end
            if (awaddr_r == adc_seq_pkg::OFF_CTRL3 && wstrb_r[1])
            begin
                samc_r <= wdata_r[adc_seq_pkg::SAMC_MSB:adc_seq_pkg::SAMC_LSB];
            end
            if (awaddr_r == adc_seq_pkg::OFF_CTRL3 && wstrb_r[0])
            begin
                div_r <= wdata_r[DIV_W-1:0];
            end
            if (awaddr_r == adc_seq_pkg::OFF_MASK && wstrb_r[0])
            begin
                mask_r <= wdata_r[1:0];
            end
            if (awaddr_r == adc_seq_pkg::OFF_MODE && wstrb_r[0])
            begin
                res12_r <= wdata_r[adc_seq_pkg::BIT_RES12];
            end
        end
    end

    adc_tad_gen #(
        .DIV_W(DIV_W)
    ) u_tad (
        .clk(clk),
        .rstn(rstn),
        .run(enable_r),
        .div(div_r),
        .tick(tad_tick)
    );

    adc_trig_sync u_ext (.clk(clk), .rstn(rstn), .async_in(ext_external_interrupt_zero_trig), .pulse(ext_p));
    adc_trig_sync u_tma (.clk(clk), .rstn(rstn), .async_in(timer_a_trig), .pulse(tma_p));
    adc_trig_sync u_pwm (.clk(clk), .rstn(rstn), .async_in(pwm_event_trig), .pulse(pwm_p));
    adc_trig_sync u_tmb (.clk(clk), .rstn(rstn), .async_in(timer_b_trig), .pulse(tmb_p));

    // Hardware trigger decode; codes 101 and 110 select no source.
    always_comb
    begin
        unique case (trig_sel_r)
            adc_seq_pkg::TRIG_EXT_EXTERNAL_INTERRUPT_ZERO: hw_trig = ext_p;
            adc_seq_pkg::TRIG_TIMER_A: hw_trig = tma_p;
            adc_seq_pkg::TRIG_PWM_EVENT: hw_trig = pwm_p;
            adc_seq_pkg::TRIG_TIMER_B: hw_trig = tmb_p;
            default: hw_trig = 1'b0;
        endcase
    end

    // Start of conversion while sampling, per trigger source.
    always_comb
    begin
        soc = 1'b0;
        if (state_r == adc_seq_pkg::ST_SAMPLE)
        begin
            if (trig_sel_r == adc_seq_pkg::TRIG_MANUAL)
            begin
                soc = sample_control_bit_clear_wr;
            end
            else if (trig_sel_r == adc_seq_pkg::TRIG_AUTO)
            begin
                soc = tad_tick && cnt_r >= samc_r;
            end
            else
            begin
                soc = hw_trig;
            end
        end
    end

    assign conv_end = state_r == adc_seq_pkg::ST_CONVERT && tad_tick
        && cnt_r == (res12_r ? adc_seq_pkg::CONV_CYC_12BIT : adc_seq_pkg::CONV_CYC_10BIT) - 5'h1;
    assign sample_control_bit_start = (state_r == adc_seq_pkg::ST_IDLE && enable_r && (auto_sample_enable_r || sample_control_bit_set_wr))
        || (conv_end && auto_sample_enable_r);

    // Sequencer: idle, sample, start latency, convert.
    always_ff @(posedge clk)
    begin
        if (!rstn || !enable_r)
        begin
            state_r <= adc_seq_pkg::ST_IDLE;
            cnt_r <= 5'h00;
            lat_r <= 2'h0;
        end
        else
        begin
            unique case (state_r)
                adc_seq_pkg::ST_IDLE:
                begin
                    cnt_r <= 5'h00;
                    if (sample_control_bit_start)
                    begin
                        state_r <= adc_seq_pkg::ST_SAMPLE;
                    end
                end
                adc_seq_pkg::ST_SAMPLE:
                begin
                    if (soc)
                    begin
                        state_r <= adc_seq_pkg::ST_LATENCY;
                        lat_r <= 2'h0;
                    end
                    else if (tad_tick && cnt_r != 5'h1F)
                    begin
                        cnt_r <= cnt_r + 5'h1;
                    end
                end
                adc_seq_pkg::ST_LATENCY:
                begin
                    cnt_r <= 5'h00;
                    if (tad_tick)
                    begin
                        lat_r <= lat_r + 2'h1;
                        if (lat_r == adc_seq_pkg::START_LATENCY - 2'h1)
                        begin
                            state_r <= adc_seq_pkg::ST_CONVERT;
                        end
                    end
                end
                adc_seq_pkg::ST_CONVERT:
                begin
                    if (conv_end)
                    begin
                        state_r <= auto_sample_enable_r ? adc_seq_pkg::ST_SAMPLE : adc_seq_pkg::ST_IDLE;
                        cnt_r <= 5'h00;
                    end
                    else if (tad_tick)
                    begin
                        cnt_r <= cnt_r + 5'h1;
                    end
                end
            endcase
        end
    end

    // Sample bit mirrors the sampling phase; it drops when sampling ends.
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            sample_control_bit_r <= 1'b0;
        end
        else if (sample_control_bit_start)
        begin
            sample_control_bit_r <= 1'b1;
        end
        else if (soc || !enable_r || state_r != adc_seq_pkg::ST_SAMPLE)
        begin
            sample_control_bit_r <= 1'b0;
        end
    end

    // Done flag: set wins over a software clear in the same cycle.
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            done_r <= 1'b0;
        end
        else if (conv_end)
        begin
            done_r <= 1'b1;
        end
        else if (wr_ctrl1 && !wdata_r[adc_seq_pkg::BIT_DONE])
        begin
            done_r <= 1'b0;
        end
    end

    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign s_axi_arready = !s_axi_rvalid;

    // Sticky events; reading the status register clears them, but a new event wins.
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            status_r <= 2'h0;
        end
        else
        begin
            status_r[adc_seq_pkg::ST_CONV_DONE] <= conv_end
                || (status_r[adc_seq_pkg::ST_CONV_DONE]
                && !(rd_fire && s_axi_araddr == adc_seq_pkg::OFF_STATUS));
            status_r[adc_seq_pkg::ST_SAMPLE_START] <= sample_control_bit_start
                || (status_r[adc_seq_pkg::ST_SAMPLE_START]
                && !(rd_fire && s_axi_araddr == adc_seq_pkg::OFF_STATUS));
        end
    end

    always_comb
    begin
        rdata_nxt = 32'h00000000;
        unique case (s_axi_araddr)
            adc_seq_pkg::OFF_CTRL1: rdata_nxt = {16'h0000, enable_r, 7'h00, trig_sel_r,
                2'h0, auto_sample_enable_r, sample_control_bit_r, done_r};
            adc_seq_pkg::OFF_CTRL3: rdata_nxt = {19'h00000, samc_r, 8'(div_r)};
            adc_seq_pkg::OFF_STATUS: rdata_nxt = {28'h0000000, 2'(state_r), status_r};
            adc_seq_pkg::OFF_MASK: rdata_nxt = {30'h00000000, mask_r};
            adc_seq_pkg::OFF_MODE: rdata_nxt = {31'h00000000, res12_r};
            default: rdata_nxt = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= adc_seq_pkg::RESP_OKAY;
        end
        else if (rd_fire)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdata_nxt;
            s_axi_rresp <= (s_axi_araddr[5:2] <= 4'h4 && s_axi_araddr[1:0] == 2'h0)
                ? adc_seq_pkg::RESP_OKAY : adc_seq_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            sample_connect <= 1'b0;
            convert_active <= 1'b0;
            conv_done_pulse <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            sample_connect <= state_r == adc_seq_pkg::ST_SAMPLE && !soc;
            convert_active <= state_r == adc_seq_pkg::ST_CONVERT;
            conv_done_pulse <= conv_end;
            irq <= |(status_r & mask_r);
        end
    end

    // Clocks spent converting; a counter keeps the length check cheap for any divider.
    logic [11:0] conv_cyc_r;

    always_ff @(posedge clk)
    begin
        if (!rstn || state_r != adc_seq_pkg::ST_CONVERT)
        begin
            conv_cyc_r <= 12'h000;
        end
        else
        begin
            conv_cyc_r <= conv_cyc_r + 12'h001;
        end
    end

    AST_CONV_LEN: assert property (@(posedge clk) disable iff (!rstn)
        conv_end |-> conv_cyc_r + 12'h001 == 12'(res12_r ? adc_seq_pkg::CONV_CYC_12BIT
        : adc_seq_pkg::CONV_CYC_10BIT) * (12'(div_r) + 12'h001))
        else $error("Conversion length wrong.");
    AST_LATENCY: assert property (@(posedge clk) disable iff (!rstn)
        soc && div_r == '0 |=> state_r == adc_seq_pkg::ST_LATENCY ##2
        state_r == adc_seq_pkg::ST_CONVERT) else $error("Start latency wrong.");
    AST_DONE_SET: assert property (@(posedge clk) disable iff (!rstn)
        conv_end |=> done_r && conv_done_pulse) else $error("Done flag not set.");
    AST_AUTO_RESAMPLE: assert property (@(posedge clk) disable iff (!rstn)
        conv_end && auto_sample_enable_r && enable_r |=> state_r == adc_seq_pkg::ST_SAMPLE)
        else $error("Auto sampling did not restart.");
    AST_MANUAL_HOLD: assert property (@(posedge clk) disable iff (!rstn)
        state_r == adc_seq_pkg::ST_IDLE && !auto_sample_enable_r && !sample_control_bit_set_wr |=>
        state_r != adc_seq_pkg::ST_SAMPLE) else $error("Sampling began unasked.");
    AST_MANUAL_CONV: assert property (@(posedge clk) disable iff (!rstn)
        state_r == adc_seq_pkg::ST_SAMPLE && trig_sel_r == adc_seq_pkg::TRIG_MANUAL
        && !sample_control_bit_clear_wr && enable_r |=> state_r == adc_seq_pkg::ST_SAMPLE)
        else $error("Manual conversion without clear.");
    AST_AUTO_TRIG: assert property (@(posedge clk) disable iff (!rstn)
        soc && trig_sel_r == adc_seq_pkg::TRIG_AUTO |-> cnt_r >= samc_r)
        else $error("Self-timed sampling ended early.");
    AST_HW_TRIG: assert property (@(posedge clk) disable iff (!rstn)
        state_r == adc_seq_pkg::ST_SAMPLE && hw_trig && enable_r
        && trig_sel_r != adc_seq_pkg::TRIG_MANUAL && trig_sel_r != adc_seq_pkg::TRIG_AUTO
        |=> state_r == adc_seq_pkg::ST_LATENCY) else $error("Trigger ignored.");
    AST_IRQ: assert property (@(posedge clk) disable iff (!rstn)
        ##1 irq == $past(|(status_r & mask_r))) else $error("Interrupt level wrong.");
    COV_MANUAL: cover property (@(posedge clk) disable iff (!rstn)
        sample_control_bit_clear_wr && state_r == adc_seq_pkg::ST_SAMPLE);
    COV_AUTO: cover property (@(posedge clk) disable iff (!rstn)
        conv_end && auto_sample_enable_r && trig_sel_r == adc_seq_pkg::TRIG_AUTO);
    COV_HW: cover property (@(posedge clk) disable iff (!rstn) soc && hw_trig);
    COV_12BIT: cover property (@(posedge clk) disable iff (!rstn) conv_end && res12_r);
endmodule

/* verification/trig_src_model.sv */
// Model of the on-chip trigger sources that feed the sequencer.
`timescale 1ns/1ps
module trig_src_model (
    input wire logic clk,
    input wire logic [3:0] fire,
    output logic [3:0] line
);
    // Each request is stretched over three clocks so the two-flop synchroniser cannot miss it.
    logic [1:0] cnt [4] = '{default: 2'h0};
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (fire[i])
                cnt[i] <= 2'h3;
            else if (cnt[i] != 2'h0)
                cnt[i] <= cnt[i] - 2'h1;
        end
    end
    assign line = {cnt[3] != 2'h0, cnt[2] != 2'h0, cnt[1] != 2'h0, cnt[0] != 2'h0};
endmodule

/* verification/test_adc_sample_convert_sequencer.sv */
// Self-checking bench for the sample and conversion sequencer.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_adc_sample_convert_sequencer;
    typedef struct packed {logic [5:0] a; logic [31:0] d; logic [1:0] r;} row_t;
    localparam logic [31:0] EN_B = 32'h1 << adc_seq_pkg::BIT_ENABLE;
    localparam logic [31:0] SAMPLE_B = 32'h1 << adc_seq_pkg::BIT_SAMPLE;
    localparam logic [31:0] AUTO_B = 32'h1 << adc_seq_pkg::BIT_AUTO_SAMPLE;
    localparam logic [31:0] TAUTO = 32'h7 << adc_seq_pkg::TRIG_LSB;
    row_t rows [7] = '{
        '{6'h00, 32'h0, 2'h0}, '{6'h04, 32'h3, 2'h0}, '{6'h08, 32'h0, 2'h0},
        '{6'h0C, 32'h0, 2'h0}, '{6'h10, 32'h0, 2'h0}, '{6'h14, 32'h0, 2'h2},
        '{6'h02, 32'h0, 2'h2}};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [5:0] awaddr = 6'h0, araddr = 6'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [3:0] fire = 4'h0;
    logic [3:0] trig;
    logic awready, wready, bvalid, arready, rvalid, sample_connect, convert_active, irq, done_p;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [2:0] obs;
    int num_errors = 0, compares = 0, n, pulses = 0;
    int lens [2];
    assign obs = {irq, convert_active, sample_connect};
    always @(posedge clk)
    begin
        if (done_p === 1'b1)
            pulses++;
    end
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    trig_src_model src (.clk(clk), .fire(fire), .line(trig));
    adc_sample_convert_sequencer dut (
        .clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ext_external_interrupt_zero_trig(trig[0]), .timer_a_trig(trig[1]), .pwm_event_trig(trig[2]),
        .timer_b_trig(trig[3]), .sample_connect(sample_connect),
        .convert_active(convert_active), .conv_done_pulse(done_p), .irq(irq));
    task automatic stop_test();
        if (num_errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic tmo();
        num_errors++;
        stop_test();
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d,
        input logic [1:0] er = adc_seq_pkg::RESP_OKAY);
        int k;
        k = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            k++;
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1 && k < 40);
        bready <= 1'b0;
        if (k >= 40)
            tmo();
        `CHK(bresp, er)
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e,
        input logic [1:0] er = adc_seq_pkg::RESP_OKAY);
        int k;
        k = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            k++;
            if (arready === 1'b1)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1 && k < 40);
        rready <= 1'b0;
        if (k >= 40)
            tmo();
        `CHK(rdata, e)
        `CHK(rresp, er)
    endtask
    task automatic ctl(input logic [31:0] v);
        wr(adc_seq_pkg::OFF_CTRL1, v);
    endtask
    // Counts edges until the watched output reaches the level, so it also measures durations.
    task automatic wt(input int i, input logic v, input int lim, output int k);
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (obs[i] !== v && k < lim);
        if (obs[i] !== v)
            tmo();
    endtask
    task automatic quiet(input int k);
        repeat (k)
        begin
            @(posedge clk);
            `CHK(convert_active, 1'b0)
        end
    endtask
    task automatic pulse(input logic [3:0] f);
        fire <= f;
        @(posedge clk);
        fire <= 4'h0;
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        `CHK(obs, 3'h0)
        rstn <= 1'b1;
        foreach (rows[i]) rd(rows[i].a, rows[i].d, rows[i].r);
        wr(6'h14, 32'hFFFF, adc_seq_pkg::RESP_SLVERR);
        // Divider 1 gives a converter period of two clocks.
        wr(6'h04, 32'h1);
        wr(6'h0C, 32'h1);
        ctl(EN_B);
        ctl(EN_B | SAMPLE_B);
        wt(0, 1'b1, 20, n);
        `CHK(convert_active, 1'b0)
        ctl(EN_B);
        wt(1, 1'b1, 40, n);
        `CHK(sample_connect, 1'b0)
        wt(1, 1'b0, 100, n);
        `CHK(n, 24)
        wt(2, 1'b1, 6, n);
        rd(6'h00, EN_B | 32'h1);
        rd(6'h08, 32'h3);
        wt(2, 1'b0, 6, n);
        rd(6'h08, 32'h0);
        ctl(EN_B);
        rd(6'h00, EN_B);
        wr(6'h0C, 32'h0);
        for (int c = 1; c < 6; c++)
        begin
            ctl(32'(c) << adc_seq_pkg::TRIG_LSB);
            ctl(EN_B | (32'(c) << adc_seq_pkg::TRIG_LSB));
            ctl(EN_B | SAMPLE_B | (32'(c) << adc_seq_pkg::TRIG_LSB));
            wt(0, 1'b1, 20, n);
            pulse(c == 5 ? 4'hF : 4'h1 << (c % 4));
            quiet(30);
            if (c < 5)
            begin
                pulse(4'h1 << (c - 1));
                wt(1, 1'b1, 40, n);
                wt(1, 1'b0, 100, n);
            end
            ctl(32'h0);
        end
        wr(6'h10, 32'h1);
        for (int s = 0; s < 2; s++)
        begin
            wr(6'h04, ((s == 0 ? 32'd4 : 32'd31) << adc_seq_pkg::SAMC_LSB) | 32'h1);
            ctl(AUTO_B | TAUTO);
            ctl(EN_B | AUTO_B | TAUTO);
            wt(1, 1'b1, 400, n);
            wt(1, 1'b0, 100, n);
            `CHK(n, 28)
            wt(0, 1'b1, 8, n);
            wt(0, 1'b0, 200, n);
            lens[s] = n;
            ctl(AUTO_B | TAUTO);
        end
        `CHK(lens[1] - lens[0], 54)
        `CHK(irq, 1'b0)
        rd(6'h08, 32'h3);
        ctl(AUTO_B);
        ctl(EN_B | AUTO_B);
        wt(0, 1'b1, 20, n);
        quiet(40);
        ctl(EN_B | AUTO_B | SAMPLE_B);
        ctl(EN_B | AUTO_B);
        wt(1, 1'b1, 40, n);
        wt(1, 1'b0, 100, n);
        wt(0, 1'b1, 8, n);
        ctl(EN_B | AUTO_B | SAMPLE_B);
        ctl(EN_B | AUTO_B);
        wt(1, 1'b1, 40, n);
        // A reset in mid-conversion must drop the sample, convert and interrupt outputs and return the CTRL1 and CTRL3 settings to their reset values.
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(obs, 3'h0)
        rstn <= 1'b1;
        rd(6'h00, 32'h0);
        rd(6'h04, 32'h3);
        quiet(10);
        `CHK(pulses, 8)
        stop_test();
    end
endmodule
